// ---- src/gdts_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gdts_map.svh"
module gdts_top #(
    parameter int PHASES  = 3,
    parameter int OCP_DEG = `GDTS_OCP_DEG_HW_CYC
) (
    input  wire logic                      clk_in,
    input  wire logic                      rstn_in,
    input  wire logic [PHASES-1:0]         high_side_input_in,
    input  wire logic [PHASES-1:0]         low_side_input_in,
    input  wire logic [PHASES-1:0]         vgs_high_on_in,
    input  wire logic [PHASES-1:0]         vgs_low_on_in,
    input  wire logic [PHASES-1:0]         switch_node_high_in,
    input  wire logic [PHASES-1:0]         vds_high_trip_in,
    input  wire logic [PHASES-1:0]         vds_low_trip_pos_in,
    input  wire logic [PHASES-1:0]         vds_low_trip_neg_in,
    input  wire logic                      serial_variant_in,
    input  wire logic                      cfg_write_in,
    input  wire gdts_pkg::gdts_count_t     cfg_window_cycles_in,
    input  wire gdts_pkg::gdts_count_t     cfg_dead_cycles_in,
    input  wire gdts_pkg::gdts_count_t     cfg_ocp_deglitch_in,
    input  wire gdts_pkg::gdts_code_t      cfg_gate_current_in,
    input  wire gdts_pkg::gdts_code_t      cfg_trip_level_in,
    input  wire logic                      cfg_low_side_monitor_ref_select_in,
    input  wire logic                      cfg_cycle_by_cycle_in,
    input  wire logic                      cfg_ocp_shutdown_in,
    input  wire logic [5:0]                gate_current_pin_in,
    input  wire logic [5:0]                trip_level_pin_in,
    input  wire logic                      clear_faults_in,
    output logic [PHASES-1:0]              gate_high_out,
    output logic [PHASES-1:0]              gate_low_out,
    output logic [PHASES-1:0]              pulldown_high_out,
    output logic [PHASES-1:0]              pulldown_low_out,
    output logic [PHASES-1:0]              gate_hold_current_out,
    output gdts_pkg::gdts_code_t           gate_current_setting_out,
    output gdts_pkg::gdts_code_t           overcurrent_trip_level_out,
    output logic [PHASES-1:0]              gate_fault_out,
    output logic [PHASES-1:0]              overcurrent_fault_out,
    output logic                           fault_indication_out,
    output logic                           fault_indication_oe_n_out
);
    import gdts_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Thermometer code from the pin comparators, 0 to 6
    function automatic logic [2:0] level7(input logic [5:0] therm);
        logic [2:0] lvl;
        lvl = 3'h0;
        for (int i = 0; i < `GDTS_PIN_LEVELS - 1; i++) begin
            if (therm[i]) begin
                lvl = 3'(i + 1);
            end
        end
        return lvl;
    endfunction : level7

    // Spread seven pin levels over the codes 0 to top
    function automatic gdts_code_t spread7(input logic [2:0] lvl, input gdts_code_t top);
        logic [7:0] prod;
        prod = 8'(lvl) * 8'(top);
        return gdts_code_t'(prod / 8'h06);
    endfunction : spread7

    // ****************************************
    // Configuration storage
    // ****************************************
    gdts_count_t window_cyc;
    gdts_count_t dead_cyc;
    gdts_count_t ocp_cyc;
    gdts_code_t  current_cfg;
    gdts_code_t  trip_cfg;
    logic        low_side_monitor_ref_select_neg;
    logic        cbc_mode;
    logic        ocp_shutdown;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            window_cyc   <= `GDTS_RST_WINDOW_CYC;
            dead_cyc     <= `GDTS_RST_DEAD_CYC;
            ocp_cyc      <= `GDTS_RST_OCP_DEG_CYC;
            current_cfg  <= `GDTS_RST_CURRENT;
            trip_cfg     <= `GDTS_RST_TRIP;
            low_side_monitor_ref_select_neg   <= 1'b0;
            cbc_mode     <= 1'b1;
            ocp_shutdown <= 1'b1;
        end else if (cfg_write_in) begin
            window_cyc   <= cfg_window_cycles_in;
            dead_cyc     <= cfg_dead_cycles_in;
            ocp_cyc      <= cfg_ocp_deglitch_in;
            current_cfg  <= cfg_gate_current_in;
            trip_cfg     <= cfg_trip_level_in;
            low_side_monitor_ref_select_neg   <= cfg_low_side_monitor_ref_select_in;
            cbc_mode     <= cfg_cycle_by_cycle_in;
            ocp_shutdown <= cfg_ocp_shutdown_in;
        end
    end

    // ****************************************
    // Setting selection per variant
    // ****************************************
    gdts_count_t ocp_limit;
    assign ocp_limit = serial_variant_in ? ocp_cyc : gdts_count_t'(OCP_DEG);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            gate_current_setting_out   <= `GDTS_RST_CURRENT;
            overcurrent_trip_level_out <= `GDTS_RST_TRIP;
        end else if (serial_variant_in) begin
            gate_current_setting_out   <= current_cfg;
            overcurrent_trip_level_out <= trip_cfg;
        end else begin
            gate_current_setting_out   <= spread7(level7(gate_current_pin_in), 4'hF);
            overcurrent_trip_level_out <= spread7(level7(trip_level_pin_in), `GDTS_TRIP_CODE_1V);
        end
    end

    // ****************************************
    // Input deglitch and delay
    // ****************************************
    gdts_filt_if #(.WIDTH(2 * PHASES)) in_if ();
    assign in_if.raw = {low_side_input_in, high_side_input_in};

    gdts_deglitch #(
        .WIDTH  (2 * PHASES),
        .CYCLES (`GDTS_IN_DEGLITCH_CYC)
    ) u_deglitch (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .port    (in_if)
    );

    // One extra stage lets the command settle before dead-time decisions
    logic [2*PHASES-1:0] in_dly;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            in_dly <= '0;
        end else begin
            in_dly <= in_if.filt;
        end
    end

    // ****************************************
    // Per-phase sequencer
    // ****************************************
    for (genvar p = 0; p < PHASES; p++) begin : g_phase
        gdts_state_t state;
        gdts_cmd_t   cmd;
        gdts_cmd_t   cmd_q;
        gdts_count_t seq_cnt;
        gdts_count_t win_cnt;
        gdts_count_t ocp_cnt;
        logic        win_active;
        logic        sw_high;
        logic        sw_on;
        logic        hs_in_q;
        logic        ls_in_q;
        logic        pwm_rise;
        logic        vds_trip;
        logic        opp_off;
        logic        win_end;
        logic        vgs_ok;
        logic        oc_set;

        always_comb begin
            if (in_dly[p] && !in_dly[PHASES+p]) begin
                cmd = GDTS_CMD_HS;
            end else if (in_dly[PHASES+p] && !in_dly[p]) begin
                cmd = GDTS_CMD_LS;
            end else begin
                cmd = GDTS_CMD_OFF;
            end
        end

        // Opposite of the target reads off on its own monitor
        assign opp_off = (cmd_q == GDTS_CMD_HS) ? !vgs_low_on_in[p] : !vgs_high_on_in[p];

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                state   <= GDTS_ST_OFF;
                cmd_q   <= GDTS_CMD_OFF;
                seq_cnt <= '0;
            end else if (cmd != cmd_q || (ocp_shutdown && overcurrent_fault_out[p])) begin
                cmd_q   <= (ocp_shutdown && overcurrent_fault_out[p]) ? GDTS_CMD_OFF : cmd;
                state   <= (cmd == GDTS_CMD_OFF) ? GDTS_ST_OFF : GDTS_ST_WAIT_OFF;
                seq_cnt <= '0;
            end else begin
                case (state)
                    GDTS_ST_OFF: begin
                        seq_cnt <= '0;
                    end
                    GDTS_ST_WAIT_OFF: begin
                        if (opp_off) begin
                            seq_cnt <= '0;
                            if (cmd_q == GDTS_CMD_LS && switch_node_high_in[p]) begin
                                state <= GDTS_ST_EXTRA;
                            end else begin
                                state <= GDTS_ST_DEAD;
                            end
                        end
                    end
                    GDTS_ST_EXTRA: begin
                        // Held-up switch node needs the sense node discharged
                        if (seq_cnt >= gdts_count_t'(`GDTS_HANDOFF_EXTRA_CYC - 1)) begin
                            seq_cnt <= '0;
                            state   <= GDTS_ST_DEAD;
                        end else begin
                            seq_cnt <= seq_cnt + 1'b1;
                        end
                    end
                    GDTS_ST_DEAD: begin
                        if (seq_cnt >= dead_cyc) begin
                            state <= GDTS_ST_ON;
                        end else begin
                            seq_cnt <= seq_cnt + 1'b1;
                        end
                    end
                    GDTS_ST_ON: begin
                        seq_cnt <= '0;
                    end
                    default: begin
                        state <= GDTS_ST_OFF;
                    end
                endcase
            end
        end

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                gate_high_out[p] <= 1'b0;
                gate_low_out[p]  <= 1'b0;
            end else begin
                gate_high_out[p] <= (cmd == cmd_q) && state == GDTS_ST_ON && cmd_q == GDTS_CMD_HS;
                gate_low_out[p]  <= (cmd == cmd_q) && state == GDTS_ST_ON && cmd_q == GDTS_CMD_LS;
            end
        end

        // ****************************************
        // Drive window and gate watch
        // ****************************************
        assign win_end = win_active && (win_cnt >= window_cyc);
        assign vgs_ok  = sw_high ? (vgs_high_on_in[p] == sw_on) : (vgs_low_on_in[p] == sw_on);

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                win_active <= 1'b0;
                win_cnt    <= '0;
                sw_high    <= 1'b0;
                sw_on      <= 1'b0;
            end else if (cmd != cmd_q) begin
                // Command change restarts the window to watch the previously commanded gate turn off
                win_active <= 1'b1;
                win_cnt    <= '0;
                sw_high    <= (cmd_q == GDTS_CMD_HS);
                sw_on      <= 1'b0;
            end else if (state == GDTS_ST_DEAD && seq_cnt >= dead_cyc) begin
                win_active <= 1'b1;
                win_cnt    <= '0;
                sw_high    <= (cmd_q == GDTS_CMD_HS);
                sw_on      <= 1'b1;
            end else if (win_end) begin
                win_active <= 1'b0;
            end else if (win_active) begin
                win_cnt <= win_cnt + 1'b1;
            end
        end

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                pulldown_high_out[p]     <= 1'b0;
                pulldown_low_out[p]      <= 1'b0;
                gate_hold_current_out[p] <= 1'b1;
            end else begin
                pulldown_low_out[p]      <= win_active && !win_end && sw_high;
                pulldown_high_out[p]     <= win_active && !win_end && !sw_high;
                gate_hold_current_out[p] <= !win_active || win_end;
            end
        end

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                gate_fault_out[p] <= 1'b0;
            end else if (win_end && cmd == cmd_q && !vgs_ok) begin
                gate_fault_out[p] <= 1'b1;
            end else if (clear_faults_in) begin
                gate_fault_out[p] <= 1'b0;
            end
        end

        // ****************************************
        // Drain-source overcurrent
        // ****************************************
        always_comb begin
            vds_trip = 1'b0;
            if (gate_high_out[p]) begin
                vds_trip = vds_high_trip_in[p];
            end else if (gate_low_out[p]) begin
                vds_trip = (serial_variant_in && low_side_monitor_ref_select_neg) ? vds_low_trip_neg_in[p] : vds_low_trip_pos_in[p];
            end
        end

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                ocp_cnt <= '0;
            end else if (!vds_trip) begin
                ocp_cnt <= '0;
            end else if (ocp_cnt <= ocp_limit) begin
                ocp_cnt <= ocp_cnt + 1'b1;
            end
        end

        assign oc_set = vds_trip && (ocp_cnt >= ocp_limit);

        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                hs_in_q <= 1'b0;
                ls_in_q <= 1'b0;
            end else begin
                hs_in_q <= in_dly[p];
                ls_in_q <= in_dly[PHASES+p];
            end
        end
        assign pwm_rise = (in_dly[p] && !hs_in_q) || (in_dly[PHASES+p] && !ls_in_q);

        // Set wins over either clear
        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                overcurrent_fault_out[p] <= 1'b0;
            end else if (oc_set) begin
                overcurrent_fault_out[p] <= 1'b1;
            end else if (clear_faults_in || (cbc_mode && pwm_rise)) begin
                overcurrent_fault_out[p] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Open-drain fault pin
    // ****************************************
    assign fault_indication_out      = 1'b0;
    assign fault_indication_oe_n_out = ~(|gate_fault_out || |overcurrent_fault_out);
endmodule : gdts_top
`default_nettype wire

// ---- include/gdts_map.svh ----
`ifndef GDTS_MAP_SVH
`define GDTS_MAP_SVH
// ****************************************
// Timing
// ****************************************
`define GDTS_CLK_MHZ            200
`define GDTS_IN_DEGLITCH_NS     20
`define GDTS_IN_DEGLITCH_CYC    ((`GDTS_IN_DEGLITCH_NS * `GDTS_CLK_MHZ + 999) / 1000)
`define GDTS_HANDOFF_EXTRA_NS   100
`define GDTS_HANDOFF_EXTRA_CYC  ((`GDTS_HANDOFF_EXTRA_NS * `GDTS_CLK_MHZ + 999) / 1000)
`define GDTS_OCP_DEG_HW_NS      4000
`define GDTS_OCP_DEG_HW_CYC     ((`GDTS_OCP_DEG_HW_NS * `GDTS_CLK_MHZ + 999) / 1000)
// ****************************************
// Configuration reset values and pin decode constants
// ****************************************
`define GDTS_RST_WINDOW_CYC     16'h0320
`define GDTS_RST_DEAD_CYC       16'h000A
`define GDTS_RST_OCP_DEG_CYC    16'h0320
`define GDTS_RST_CURRENT        4'hF
`define GDTS_RST_TRIP           4'h7
`define GDTS_TRIP_CODE_1V       4'hB
`define GDTS_PIN_LEVELS         7
`endif

// ---- include/gdts_pkg.sv ----
package gdts_pkg;
    typedef enum logic [2:0] {
        GDTS_ST_OFF,
        GDTS_ST_WAIT_OFF,
        GDTS_ST_EXTRA,
        GDTS_ST_DEAD,
        GDTS_ST_ON
    } gdts_state_t;
    typedef enum logic [1:0] {
        GDTS_CMD_OFF,
        GDTS_CMD_HS,
        GDTS_CMD_LS
    } gdts_cmd_t;
    typedef logic [15:0] gdts_count_t;
    typedef logic [3:0]  gdts_code_t;
endpackage : gdts_pkg

// ---- include/gdts_filt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface gdts_filt_if #(
    parameter int WIDTH = 6
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] filt;
    modport filter (input raw, output filt);
    modport user   (output raw, input filt);
endinterface : gdts_filt_if
`default_nettype wire

// ---- src/gdts_deglitch.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdts_deglitch #(
    parameter int WIDTH  = 6,
    parameter int CYCLES = 4
) (
    input  wire logic     clk_in,
    input  wire logic     rstn_in,
    gdts_filt_if.filter   port
);
    localparam int CW = $clog2(CYCLES + 1);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic          last;
        logic          state;
        logic [CW-1:0] cnt;
        // A change must hold this long before it is passed on
        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                last  <= 1'b0;
                state <= 1'b0;
                cnt   <= '0;
            end else begin
                last <= port.raw[i];
                if (port.raw[i] != last || port.raw[i] == state) begin
                    cnt <= '0;
                end else if (cnt == CW'(CYCLES - 1)) begin
                    state <= port.raw[i];
                    cnt   <= '0;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
        assign port.filt[i] = state;
    end
endmodule : gdts_deglitch
`default_nettype wire

// ---- testbench/gdts_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdts_monitor #(
    parameter int PHASES  = 3,
    parameter int OCP_DEG = 8
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic [PHASES-1:0] high_side_input_in,
    input  wire logic [PHASES-1:0] low_side_input_in,
    input  wire logic [PHASES-1:0] vgs_high_on_in,
    input  wire logic [PHASES-1:0] vgs_low_on_in,
    input  wire logic [PHASES-1:0] vds_high_trip_in,
    input  wire logic [PHASES-1:0] vds_low_trip_pos_in,
    input  wire logic [PHASES-1:0] vds_low_trip_neg_in,
    input  wire logic [PHASES-1:0] gate_high_out,
    input  wire logic [PHASES-1:0] gate_low_out,
    input  wire logic [PHASES-1:0] pulldown_high_out,
    input  wire logic [PHASES-1:0] pulldown_low_out,
    input  wire logic [PHASES-1:0] gate_hold_current_out,
    input  wire logic [PHASES-1:0] overcurrent_fault_out,
    input  wire logic [PHASES-1:0] gate_fault_out,
    input  wire logic              fault_indication_out,
    input  wire logic              fault_indication_oe_n_out
);
    // ********
    // Phase 0 trip run length
    // ********
    logic [15:0] trip_run;
    always_ff @(posedge clk_in) begin
        if (!rstn_in || !(vds_high_trip_in[0] | vds_low_trip_pos_in[0] | vds_low_trip_neg_in[0])) begin
            trip_run <= 16'h0000;
        end else if (trip_run != 16'hFFFF) begin
            trip_run <= trip_run + 16'h0001;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    chk_no_overlap: assert property ((gate_high_out & gate_low_out) == '0)
        else $error("both gates of a phase on");
    chk_hs_waits_ls: assert property ($rose(gate_high_out[0]) |-> !$past(vgs_low_on_in[0]))
        else $error("high gate on while low gate still charged");
    chk_ls_waits_hs: assert property ($rose(gate_low_out[0]) |-> !$past(vgs_high_on_in[0]))
        else $error("low gate on while high gate still charged");
    chk_pulldown_low_on: assert property ($rose(gate_high_out[0]) |-> ##[0:1] pulldown_low_out[0])
        else $error("no pulldown on low gate at high turn-on");
    chk_pulldown_high_on: assert property ($rose(gate_low_out[0]) |-> ##[0:1] pulldown_high_out[0])
        else $error("no pulldown on high gate at low turn-on");
    chk_drive_current_on: assert property ($rose(gate_high_out[0]) |-> ##[0:1] !gate_hold_current_out[0])
        else $error("hold current during drive window");
    chk_fault_pin_low: assert property (fault_indication_oe_n_out == !(|gate_fault_out || |overcurrent_fault_out)
        && !fault_indication_out)
        else $error("fault pin does not follow fault flags");
    chk_oc_deglitch: assert property ($rose(overcurrent_fault_out[0]) |-> trip_run >= 16'(OCP_DEG))
        else $error("overcurrent flagged before deglitch time");
    chk_off_prompt: assert property ((!high_side_input_in[0] && !low_side_input_in[0]) [*8] |-> ##1
        !(gate_high_out[0] | gate_low_out[0]))
        else $error("gate stays on after off command");
endmodule : gdts_monitor
bind gdts_top gdts_monitor #(.PHASES(PHASES), .OCP_DEG(OCP_DEG)) u_gdts_monitor (
    .clk_in(clk_in), .rstn_in(rstn_in), .high_side_input_in(high_side_input_in),
    .low_side_input_in(low_side_input_in), .vgs_high_on_in(vgs_high_on_in), .vgs_low_on_in(vgs_low_on_in),
    .vds_high_trip_in(vds_high_trip_in), .vds_low_trip_pos_in(vds_low_trip_pos_in),
    .vds_low_trip_neg_in(vds_low_trip_neg_in), .gate_high_out(gate_high_out), .gate_low_out(gate_low_out),
    .pulldown_high_out(pulldown_high_out), .pulldown_low_out(pulldown_low_out),
    .gate_hold_current_out(gate_hold_current_out), .overcurrent_fault_out(overcurrent_fault_out),
    .gate_fault_out(gate_fault_out), .fault_indication_out(fault_indication_out),
    .fault_indication_oe_n_out(fault_indication_oe_n_out));
`default_nettype wire

// ---- testbench/gdts_gate_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdts_gate_model #(
    parameter int DLY = 4
) (
    input  wire logic       clk_in,
    input  wire logic [2:0] gate_high_in,
    input  wire logic [2:0] gate_low_in,
    input  wire logic [2:0] stuck_low_in,
    output logic      [2:0] vgs_high_on_out,
    output logic      [2:0] vgs_low_on_out
);
    // ********
    // Gate charge delay
    // ********
    logic [2:0] hp [DLY];
    logic [2:0] lp [DLY];
    always_ff @(posedge clk_in) begin
        // Broken gate connection never charges
        hp[0] <= gate_high_in & ~stuck_low_in;
        lp[0] <= gate_low_in;
        for (int i = 1; i < DLY; i++) begin
            hp[i] <= hp[i-1];
            lp[i] <= lp[i-1];
        end
    end
    assign vgs_high_on_out = hp[DLY-1];
    assign vgs_low_on_out  = lp[DLY-1];
endmodule : gdts_gate_model
`default_nettype wire

// ---- testbench/gdts_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gdts_map.svh"
module gdts_top_tb_top;
    import gdts_pkg::*;
    localparam int DEAD = 3;
    localparam int XTRA = `GDTS_HANDOFF_EXTRA_CYC;
    logic       clk_in = 0, rstn_in = 0, cfg_wr = 0, clr = 0;
    logic [2:0] hs = 0, ls = 0, sw = 0, vt_h = 0, vt_p = 0, vt_n = 0, stuck = 0;
    logic [2:0] vgs_h, vgs_l, gh, gl, pdh, pdl, hold, gf, ocf;
    gdts_code_t cur, trip;
    logic       fo, oen;
    logic       serial = 1, low_side_monitor_ref_select = 0, cbc = 1, shut = 1;
    logic [5:0] cpin = 0, tpin = 0;
    int         error_cnt = 0, cmp_count = 0, n;
    logic [3:0] rows [5] = '{4'b1010, 4'b0101, 4'b0000, 4'b1100, 4'b1010};
    always #2.5 clk_in = ~clk_in;
    // Window 30 well above model charge delay 4
    gdts_top #(.OCP_DEG(8)) u_gdts_top (
        .clk_in(clk_in), .rstn_in(rstn_in), .high_side_input_in(hs), .low_side_input_in(ls),
        .vgs_high_on_in(vgs_h), .vgs_low_on_in(vgs_l), .switch_node_high_in(sw), .vds_high_trip_in(vt_h),
        .vds_low_trip_pos_in(vt_p), .vds_low_trip_neg_in(vt_n), .serial_variant_in(serial),
        .cfg_write_in(cfg_wr), .cfg_window_cycles_in(16'h001E), .cfg_dead_cycles_in(16'(DEAD)),
        .cfg_ocp_deglitch_in(16'h0008), .cfg_gate_current_in(4'h5), .cfg_trip_level_in(4'h9),
        .cfg_low_side_monitor_ref_select_in(low_side_monitor_ref_select), .cfg_cycle_by_cycle_in(cbc), .cfg_ocp_shutdown_in(shut),
        .gate_current_pin_in(cpin), .trip_level_pin_in(tpin), .clear_faults_in(clr),
        .gate_high_out(gh), .gate_low_out(gl), .pulldown_high_out(pdh), .pulldown_low_out(pdl),
        .gate_hold_current_out(hold), .gate_current_setting_out(cur), .overcurrent_trip_level_out(trip),
        .gate_fault_out(gf), .overcurrent_fault_out(ocf), .fault_indication_out(fo),
        .fault_indication_oe_n_out(oen));
    gdts_gate_model #(.DLY(4)) u_gdts_gate_model (.clk_in(clk_in), .gate_high_in(gh), .gate_low_in(gl),
        .stuck_low_in(stuck), .vgs_high_on_out(vgs_h), .vgs_low_on_out(vgs_l));
    // ********
    // Helpers
    // ********
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic look(input int k);
        repeat (k) @(posedge clk_in);
        @(negedge clk_in);
    endtask : look
    // Cycles from opposite gate discharged to target gate on
    task automatic measure(input logic h, input logic sn, output int cnt);
        int k;
        @(posedge clk_in);
        hs <= {3{h}};
        ls <= {3{!h}};
        sw <= {3{sn}};
        cnt = 0;
        for (k = 0; k < 300 && (h ? gh[0] : gl[0]) !== 1'b1; k++) begin
            @(negedge clk_in);
            cnt = (h ? vgs_l[0] : vgs_h[0]) ? 0 : cnt + 1;
        end
    endtask : measure
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        give_verdict();
    end
    // ********
    // Tests
    // ********
    initial begin
        look(10);
        check(16'(gh | gl | pdh | pdl | gf | ocf), 16'h0000);
        check(16'({hold, oen, cur, trip}), 16'h0FF7);
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        cfg_wr <= 1'b1;
        @(posedge clk_in);
        cfg_wr <= 1'b0;
        look(3);
        check(16'({cur, trip}), 16'h0059);
        $display("test reset and config done");
        foreach (rows[i]) begin
            @(posedge clk_in);
            hs <= {3{rows[i][3]}};
            ls <= {3{rows[i][2]}};
            look(80);
            check(16'({gh, gl}), 16'({{3{rows[i][1]}}, {3{rows[i][0]}}}));
            check(16'({hold, gf}), 16'h0038);
        end
        $display("test command rows done");
        measure(1'b0, 1'b0, n);
        check(16'(n >= DEAD + 1 && n < XTRA), 16'h0001);
        measure(1'b1, 1'b0, n);
        check(16'(n >= DEAD + 1 && n < XTRA), 16'h0001);
        measure(1'b0, 1'b1, n);
        check(16'(n >= XTRA + DEAD + 1), 16'h0001);
        $display("test dead time done");
        @(posedge clk_in);
        {hs, ls, sw} <= {3'h7, 3'h0, 3'h0};
        @(posedge clk_in);
        @(posedge clk_in);
        {hs, ls} <= {3'h0, 3'h7};
        look(20);
        check(16'({gh, gl}), 16'h0007);
        @(posedge clk_in);
        {hs, ls} <= {3'h7, 3'h0};
        repeat (9) @(posedge clk_in);
        {hs, ls} <= {3'h0, 3'h7};
        look(80);
        check(16'({gh, gl, gf}), 16'h0038);
        $display("test glitch and abort done");
        @(posedge clk_in);
        {hs, ls, stuck} <= {3'h7, 3'h0, 3'h2};
        look(80);
        check(16'({gf, oen, fo}), 16'h0008);
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        {clr, stuck} <= {1'b0, 3'h0};
        look(2);
        check(16'({gf, oen}), 16'h0001);
        $display("test gate fault done");
        @(posedge clk_in);
        vt_h <= 3'h7;
        look(5);
        @(posedge clk_in);
        vt_h <= 3'h0;
        look(10);
        check(16'(ocf), 16'h0000);
        @(posedge clk_in);
        vt_h <= 3'h7;
        look(30);
        check(16'({ocf, gh, oen}), 16'h0070);
        @(posedge clk_in);
        {vt_h, hs} <= {3'h0, 3'h0};
        look(20);
        @(posedge clk_in);
        hs <= 3'h7;
        look(20);
        check(16'(ocf), 16'h0000);
        $display("test overcurrent done");
        @(posedge clk_in);
        {hs, ls} <= {3'h0, 3'h7};
        look(80);
        @(posedge clk_in);
        vt_n <= 3'h7;
        look(30);
        check(16'(ocf), 16'h0000);
        @(posedge clk_in);
        {vt_n, vt_p} <= {3'h0, 3'h7};
        look(30);
        check(16'(ocf), 16'h0007);
        @(posedge clk_in);
        {vt_p, clr} <= {3'h0, 1'b1};
        @(posedge clk_in);
        clr <= 1'b0;
        look(2);
        check(16'(ocf), 16'h0000);
        $display("test low side reference done");
        @(posedge clk_in);
        {low_side_monitor_ref_select, cbc, cfg_wr} <= {1'b1, 1'b0, 1'b1};
        @(posedge clk_in);
        {cfg_wr, vt_n} <= {1'b0, 3'h7};
        look(30);
        check(16'(ocf), 16'h0007);
        @(posedge clk_in);
        {vt_n, ls} <= {3'h0, 3'h0};
        look(20);
        @(posedge clk_in);
        ls <= 3'h7;
        look(20);
        check(16'(ocf), 16'h0007);
        @(posedge clk_in);
        {clr, serial, cpin, tpin} <= {1'b1, 1'b0, 6'h03, 6'h3F};
        @(posedge clk_in);
        clr <= 1'b0;
        look(3);
        check(16'({ocf, cur, trip}), 16'h005B);
        $display("test modes and pins done");
        give_verdict();
    end
endmodule : gdts_top_tb_top
`default_nettype wire
